// file: hdl/sbm_consts.svh
// Purpose: Constants of the synchronous burst memory interface
// Assumes: Included by the package, the top module and the bench files
// Notes:   Widths, reset levels and counts for the memory side
`ifndef SBM_CONSTS_SVH
`define SBM_CONSTS_SVH

`define SBM_AW      20
`define SBM_DW      64
`define SBM_BW      8
`define SBM_NSPACE  4
`define SBM_SW      2
`define SBM_LW      2
`define SBM_INACT   1'h1
`define SBM_ACT     1'h0
`define SBM_CE_IDLE 4'hF
`define SBM_LAT_ONE 2'h1

`endif

// file: hdl/sbm_pkg.sv
// Purpose: Types of the synchronous burst memory interface
// Assumes: Constants header in the include path
// Notes:   No imports; users write sbm_pkg::name
`include "sbm_consts.svh"

package sbm_pkg;

  // Per-space secondary control settings
  typedef struct packed {
    logic [`SBM_LW-1:0] read_latency_field;
    logic [`SBM_LW-1:0] write_latency_field;
    logic               chip_enable_extend;
    logic               strobe_function_select;
    logic               sync_clock_select;
  } sbm_space_cfg_type;

  // One user access
  typedef struct packed {
    logic               write;
    logic [`SBM_SW-1:0] space;
    logic [`SBM_AW-1:0] addr;
    logic [`SBM_BW-1:0] be;
    logic [`SBM_DW-1:0] wdata;
  } sbm_cmd_type;

  // Access with its space settings, crossing to the link
  typedef struct packed {
    sbm_cmd_type       cmd;
    sbm_space_cfg_type cfg;
  } sbm_xfer_type;

  // Control pins toward the memory
  typedef struct packed {
    logic [`SBM_NSPACE-1:0] space_chip_enable_n;
    logic [`SBM_AW-1:0]     external_address_bus;
    logic [`SBM_BW-1:0]     byte_enable_n;
    logic                   strobe_n;
    logic                   sync_output_enable_n;
    logic                   sync_write_enable_n;
    logic                   sync_clock_select;
  } sbm_pins_type;

  // Link state machine
  typedef enum logic [4:0] {
    SBM_IDLE  = 5'h01,
    SBM_CMD   = 5'h02,
    SBM_WAIT  = 5'h04,
    SBM_FIN   = 5'h08,
    SBM_DESEL = 5'h10
  } sbm_state_type;

endpackage : sbm_pkg

// file: hdl/sbm_top.sv
// Purpose: Synchronous burst SRAM / ZBT / sync FIFO access engine
// Assumes: link_clk is the output clock chosen by sync_clock_select
// Notes:   One word per request; toggle handshakes between domains
`timescale 1ns/1ps
`include "sbm_consts.svh"

module sbm_top (
  input  wire logic                                         clk,
  input  wire logic                                         srst,
  input  wire logic                                         link_clk,
  input  wire logic                                         req_valid,
  input  wire sbm_pkg::sbm_cmd_type                         req,
  input  wire sbm_pkg::sbm_space_cfg_type [`SBM_NSPACE-1:0] space_secondary_control,
  input  wire logic [`SBM_DW-1:0]                           data_in,
  output logic                                              req_ready,
  output logic                                              resp_valid,
  output logic [`SBM_DW-1:0]                                resp_rdata,
  output sbm_pkg::sbm_pins_type                             pins,
  output logic [`SBM_DW-1:0]                                data_out,
  output logic                                              data_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Shared decode

  // Active-low chip enable for one space
  function automatic logic [`SBM_NSPACE-1:0] sbm_ce_decode(
    input logic [`SBM_SW-1:0] space
  );
    logic [`SBM_NSPACE-1:0] ce;
    ce = `SBM_CE_IDLE;
    ce[space] = `SBM_ACT;
    return ce;
  endfunction : sbm_ce_decode

  // Idle pin levels: enables and strobe inactive, address, byte enables and clock select kept
  function automatic sbm_pkg::sbm_pins_type sbm_pins_idle(
    input sbm_pkg::sbm_pins_type cur
  );
    sbm_pkg::sbm_pins_type p;
    p                      = cur;
    p.space_chip_enable_n  = `SBM_CE_IDLE;
    p.strobe_n             = `SBM_INACT;
    p.sync_output_enable_n = `SBM_INACT;
    p.sync_write_enable_n  = `SBM_INACT;
    return p;
  endfunction : sbm_pins_idle

  ////////////////////////////////////////////////////////////////////////////
  // System clock side

  sbm_pkg::sbm_xfer_type  hold;
  sbm_pkg::sbm_xfer_type  next_hold;
  logic                   busy;
  logic                   next_busy;
  logic                   next_req_ready;
  logic                   req_tgl;
  logic                   next_req_tgl;
  logic                   next_resp_valid;
  logic [`SBM_DW-1:0]     next_resp_rdata;
  logic [2:0]             done_sync;
  logic                   done_tgl;
  logic [`SBM_DW-1:0]     link_rdata;

  // Accept a request, finish on returned toggle
  always_comb begin
    next_hold       = hold;
    next_busy       = busy;
    next_req_tgl    = req_tgl;
    next_resp_valid = 1'h0;
    next_resp_rdata = resp_rdata;
    if (req_ready && req_valid) begin // Refused while ready low, also just after reset
      next_hold.cmd = req;
      next_hold.cfg = space_secondary_control[req.space];
      next_req_tgl  = ~req_tgl;
      next_busy     = 1'h1;
    end
    if (done_sync[2] != done_sync[1]) begin
      next_busy       = 1'h0;
      next_resp_valid = 1'h1;
      next_resp_rdata = link_rdata;
    end
    next_req_ready = ~next_busy;
  end

  // System side registers
  always_ff @(posedge clk) begin
    if (srst) begin
      hold       <= '0;
      busy       <= 1'h0;
      req_ready  <= 1'h0;
      req_tgl    <= 1'h0;
      resp_valid <= 1'h0;
      resp_rdata <= '0;
      done_sync  <= '0;
    end else begin
      hold       <= next_hold;
      busy       <= next_busy;
      req_ready  <= next_req_ready;
      req_tgl    <= next_req_tgl;
      resp_valid <= next_resp_valid;
      resp_rdata <= next_resp_rdata;
      done_sync  <= {done_sync[1:0], done_tgl}; // First flop feeds second only
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link clock side

  logic [1:0]             lrst_sync;
  logic                   link_rst;
  logic [2:0]             req_sync;
  logic                   req_new;
  sbm_pkg::sbm_state_type state;
  sbm_pkg::sbm_state_type next_state;
  sbm_pkg::sbm_xfer_type  cur;
  sbm_pkg::sbm_xfer_type  next_cur;
  logic [`SBM_LW-1:0]     elapsed;
  logic [`SBM_LW-1:0]     next_elapsed;
  sbm_pkg::sbm_pins_type  next_pins;
  logic [`SBM_DW-1:0]     next_data_out;
  logic                   next_data_oe_n;
  logic [`SBM_DW-1:0]     next_link_rdata;
  logic                   next_done_tgl;
  logic                   last;
  logic [`SBM_LW-1:0]     lat;

  // Reset brought into the link domain
  always_ff @(posedge link_clk) begin
    lrst_sync <= {lrst_sync[0], srst};
  end

  assign link_rst = lrst_sync[1];
  assign req_new  = req_sync[2] != req_sync[1];
  assign lat      = cur.cmd.write ? cur.cfg.write_latency_field
                                  : cur.cfg.read_latency_field;
  assign last     = elapsed == lat;

  // Command, latency wait and deselect sequencing
  always_comb begin
    next_state      = state;
    next_cur        = cur;
    next_elapsed    = elapsed;
    next_pins       = pins;
    next_data_out   = data_out;
    next_data_oe_n  = data_oe_n;
    next_link_rdata = link_rdata;
    next_done_tgl   = done_tgl;
    case (state)
      sbm_pkg::SBM_IDLE: begin
        next_pins = sbm_pins_idle(pins);
        if (req_new) begin
          next_cur     = hold;
          next_elapsed = '0;
          next_state   = sbm_pkg::SBM_CMD;
          next_pins.sync_clock_select    = hold.cfg.sync_clock_select;
          next_pins.space_chip_enable_n  = sbm_ce_decode(hold.cmd.space);
          next_pins.external_address_bus = hold.cmd.addr;
          next_pins.byte_enable_n        = ~hold.cmd.be;
          next_pins.strobe_n             = `SBM_ACT;
          next_pins.sync_output_enable_n = hold.cmd.write;
          next_pins.sync_write_enable_n  = ~hold.cmd.write;
          // zero write latency drives with command
          if (hold.cmd.write && hold.cfg.write_latency_field == '0) begin
            next_data_out  = hold.cmd.wdata;
            next_data_oe_n = `SBM_ACT;
          end
        end
      end
      sbm_pkg::SBM_CMD, sbm_pkg::SBM_WAIT: begin
        // chip enable drops after the command, except on a read with chip_enable_extend set
        next_pins.space_chip_enable_n = `SBM_CE_IDLE;
        if (cur.cfg.chip_enable_extend && !cur.cmd.write) begin
          next_pins.space_chip_enable_n = sbm_ce_decode(cur.cmd.space);
        end
        // read enable held through a FIFO read
        next_pins.strobe_n = ~(cur.cfg.strobe_function_select && !cur.cmd.write && !last);
        next_pins.sync_write_enable_n = `SBM_INACT;
        // write data one cycle before its slot
        if (cur.cmd.write && (elapsed + `SBM_LAT_ONE) == cur.cfg.write_latency_field) begin
          next_data_out  = cur.cmd.wdata;
          next_data_oe_n = `SBM_ACT;
        end
        if (last) begin
          // read data sampled at the latency edge
          if (!cur.cmd.write) begin
            next_link_rdata = data_in;
          end
          next_pins      = sbm_pins_idle(pins);
          next_data_oe_n = `SBM_INACT;
          next_done_tgl  = ~done_tgl;
          next_state     = sbm_pkg::SBM_FIN;
        end else begin
          next_elapsed = elapsed + `SBM_LAT_ONE;
          next_state   = sbm_pkg::SBM_WAIT;
        end
      end
      sbm_pkg::SBM_FIN: begin
        if (cur.cfg.strobe_function_select) begin
          next_state = sbm_pkg::SBM_IDLE;
        end else begin
          next_state = sbm_pkg::SBM_DESEL;
        end
      end
      sbm_pkg::SBM_DESEL: begin
        next_pins  = sbm_pins_idle(pins);
        next_state = sbm_pkg::SBM_IDLE;
      end
      default: begin
        next_pins      = sbm_pins_idle(pins);
        next_data_oe_n = `SBM_INACT;
        next_state     = sbm_pkg::SBM_IDLE;
      end
    endcase
  end

  // Link side registers
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      req_sync   <= '0;
      state      <= sbm_pkg::SBM_IDLE;
      cur        <= '0;
      elapsed    <= '0;
      pins       <= '{space_chip_enable_n:  `SBM_CE_IDLE,
                      external_address_bus: '0,
                      byte_enable_n:        '1,
                      strobe_n:             `SBM_INACT,
                      sync_output_enable_n: `SBM_INACT,
                      sync_write_enable_n:  `SBM_INACT,
                      sync_clock_select:    1'h0};
      data_out   <= '0;
      data_oe_n  <= `SBM_INACT;
      link_rdata <= '0;
      done_tgl   <= 1'h0;
    end else begin
      req_sync   <= {req_sync[1:0], req_tgl}; // First flop feeds second only
      state      <= next_state;
      cur        <= next_cur;
      elapsed    <= next_elapsed;
      pins       <= next_pins;
      data_out   <= next_data_out;
      data_oe_n  <= next_data_oe_n;
      link_rdata <= next_link_rdata;
      done_tgl   <= next_done_tgl;
    end
  end

endmodule : sbm_top

// file: tb/sbm_mem_model.sv
// Purpose: Behavioural synchronous memory on the link side
// Assumes: Whole-word writes
// Notes:   Bus shows inverted last word when not enabled
`timescale 1ns/1ps
`include "sbm_consts.svh"
module sbm_mem_model (
  input  wire logic                  link_clk,
  input  wire sbm_pkg::sbm_pins_type pins,
  input  wire logic [`SBM_DW-1:0]    data_out,
  input  wire logic                  data_oe_n,
  output logic [`SBM_DW-1:0]         data_in
);
  logic [`SBM_DW-1:0] mem [16];
  logic [`SBM_DW-1:0] last = '0;
  wire  [3:0]         a = pins.external_address_bus[3:0];
  // word shown only under output enable
  always_comb data_in = pins.sync_output_enable_n ? ~last : mem[a];
  always_ff @(posedge link_clk) begin
    if (!data_oe_n) mem[a] <= data_out;
    if (!pins.sync_output_enable_n) last <= mem[a];
  end
endmodule : sbm_mem_model

// file: tb/sbm_monitor.sv
// Purpose: Link-side timing checks
// Assumes: Settings steady during an access
// Notes:   Bound to sbm_top
`timescale 1ns/1ps
`include "sbm_consts.svh"
module sbm_monitor (
  input wire logic                                         srst,
  input wire logic                                         link_clk,
  input wire sbm_pkg::sbm_space_cfg_type [`SBM_NSPACE-1:0] space_secondary_control,
  input wire sbm_pkg::sbm_pins_type                        pins,
  input wire logic                                         data_oe_n
);
  logic [1:0]                 sp_q, next_sp;
  logic [2:0]                 age, lowc;
  logic                       idle_q, cmd;
  sbm_pkg::sbm_space_cfg_type cf;
  ////////////////////////////////////////////////////////////////
  // Command edge and the space it opens
  always_comb begin
    cmd = (pins.space_chip_enable_n != `SBM_CE_IDLE) && idle_q;
    next_sp = sp_q;
    for (int i = 0; i < `SBM_NSPACE; i++) begin
      if (cmd && !pins.space_chip_enable_n[i]) next_sp = 2'(i);
    end
    cf = space_secondary_control[next_sp];
  end
  // Idle flag, cycles since command, output enable run
  always_ff @(posedge link_clk) begin
    idle_q <= srst || (pins.space_chip_enable_n == `SBM_CE_IDLE);
    sp_q <= next_sp;
    age <= cmd ? 3'h1 : ((age == 3'h7) ? age : age + 3'h1);
    lowc <= pins.sync_output_enable_n ? 3'h0 : lowc + 3'h1;
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge link_clk); endclocking
  default disable iff (srst);
  // Pin timing against the space settings, plus write data length and write/output enable overlap
  a_ce_drop: assert property (cmd && !cf.chip_enable_extend |=>
    pins.space_chip_enable_n == `SBM_CE_IDLE) else $error("chip enable held");
  a_ce_extend: assert property (cf.chip_enable_extend && !pins.sync_output_enable_n |->
    pins.space_chip_enable_n != `SBM_CE_IDLE) else $error("chip enable dropped");
  a_oe_length: assert property ($rose(pins.sync_output_enable_n) |->
    lowc == {1'b0, cf.read_latency_field} + 3'h1) else $error("read window length");
  a_wdata_lat: assert property ($fell(data_oe_n) |->
    (cmd ? 3'h0 : age) == {1'b0, cf.write_latency_field}) else $error("write latency");
  a_wdata_once: assert property (!data_oe_n |=> data_oe_n)
    else $error("write data too long");
  a_ads_pulse: assert property (cmd && !cf.strobe_function_select |=> pins.strobe_n)
    else $error("address strobe too long");
  a_fifo_rd_run: assert property (cmd && cf.strobe_function_select &&
    pins.sync_write_enable_n && cf.read_latency_field != 2'h0 |=> !pins.strobe_n)
    else $error("read enable too short");
  a_we_oe_apart: assert property (pins.sync_write_enable_n || pins.sync_output_enable_n)
    else $error("write and output enable together");
  a_clk_choice: assert property (cmd |-> pins.sync_clock_select == cf.sync_clock_select)
    else $error("clock select wrong");
  // Main scenarios
  c_write: cover property (cmd && !pins.sync_write_enable_n);
  c_ext_read: cover property (cmd && cf.chip_enable_extend && pins.sync_write_enable_n);
  c_rl_three: cover property ($rose(pins.sync_output_enable_n) && lowc == 3'h4);
endmodule : sbm_monitor
bind sbm_top sbm_monitor mon (.srst(srst), .link_clk(link_clk), .pins(pins),
  .space_secondary_control(space_secondary_control), .data_oe_n(data_oe_n));

// file: tb/sbm_top_bench.sv
// Purpose: Bench for the burst memory engine
// Assumes: Memory model on the link side
// Notes:   Table rows, then a mid-run reset
`timescale 1ns/1ps
`include "sbm_consts.svh"
`define SBM_CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t got %h expected %h", $time, got, exp); end end
module sbm_top_bench;
  typedef struct packed {
    logic        w;
    logic [1:0]  sp;
    logic [19:0] ad;
    logic [15:0] d;
  } sbm_row_type;
  logic                                       clk = 1'b0;
  logic                                       link_clk = 1'b0;
  logic                                       srst = 1'b1;
  logic                                       req_valid = 1'b0;
  logic                                       req_ready, resp_valid, data_oe_n;
  logic [`SBM_DW-1:0]                         data_in, resp_rdata, data_out, rd;
  sbm_pkg::sbm_cmd_type                       req = '0;
  sbm_pkg::sbm_pins_type                      pins;
  sbm_pkg::sbm_space_cfg_type [`SBM_NSPACE-1:0] cfg = {7'h7F, 7'h50, 7'h2F, 7'h00};
  int                                         fails = 0;
  int                                         n_compared = 0;
  int                                         cycles = 0;
  sbm_row_type rows [10] = '{'{1'b1, 2'h0, 20'h0_0001, 16'hA111},
    '{1'b0, 2'h0, 20'h0_0001, 16'hA111}, '{1'b1, 2'h1, 20'h0_0002, 16'hB222},
    '{1'b0, 2'h1, 20'h0_0002, 16'hB222}, '{1'b1, 2'h2, 20'h0_0003, 16'hC333},
    '{1'b0, 2'h2, 20'h0_0003, 16'hC333}, '{1'b1, 2'h3, 20'h0_0004, 16'hD444},
    '{1'b1, 2'h3, 20'h0_0004, 16'hE555}, '{1'b0, 2'h3, 20'h0_0004, 16'hE555},
    '{1'b0, 2'h0, 20'h0_0004, 16'hE555}};
  ////////////////////////////////////////////////////////////////
  // Clocks, link clock offset in phase
  always #20 clk = ~clk;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  sbm_top uut (.clk(clk), .srst(srst), .link_clk(link_clk), .req_valid(req_valid),
    .req(req), .space_secondary_control(cfg), .data_in(data_in), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .pins(pins), .data_out(data_out),
    .data_oe_n(data_oe_n));
  sbm_mem_model mem (.link_clk(link_clk), .pins(pins), .data_out(data_out),
    .data_oe_n(data_oe_n), .data_in(data_in));
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      print_verdict();
    end
  end
  // One access, held until taken, then wait for its response
  task automatic access(input sbm_row_type r);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req <= '{r.w, r.sp, r.ad, 8'hFF, {4{r.d}}};
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (resp_valid !== 1'b1 && n < 200);
    rd = resp_rdata;
    `SBM_CHECK(resp_valid, 1'b1)
    @(posedge clk);
  endtask : access
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    `SBM_CHECK(req_ready, 1'b0)
    `SBM_CHECK(pins.space_chip_enable_n, `SBM_CE_IDLE)
    `SBM_CHECK(data_oe_n, `SBM_INACT)
    @(posedge clk);
    srst <= 1'b0;
    // Table of writes and read-backs over all four spaces
    foreach (rows[i]) begin
      access(rows[i]);
      if (!rows[i].w) `SBM_CHECK(rd, {4{rows[i].d}})
      `SBM_CHECK(pins.external_address_bus, rows[i].ad)
      `SBM_CHECK(pins.byte_enable_n, 8'h00)
    end
    // Mid-run reset, then a latency-one read of kept data
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    `SBM_CHECK(req_ready, 1'b0)
    `SBM_CHECK(pins.space_chip_enable_n, `SBM_CE_IDLE)
    `SBM_CHECK(pins.byte_enable_n, 8'hFF)
    srst <= 1'b0;
    access(rows[3]);
    `SBM_CHECK(rd, {4{rows[3].d}})
    print_verdict();
  end
endmodule : sbm_top_bench
